//--- lfx_defs.svh
// Register offsets, field positions, reset values and timing counts of the LED touch effect block
`ifndef LFX_DEFS_SVH
`define LFX_DEFS_SVH

`define LFX_ADDR_GLOBAL_CFG     8'h01
`define LFX_ADDR_PERIOD_ONE     8'h02
`define LFX_ADDR_PERIOD_TWO     8'h03
`define LFX_ADDR_PERIOD_THREE   8'h04
`define LFX_ADDR_PERIOD_FOUR    8'h05
`define LFX_ADDR_CFG_OUT0       8'h06
`define LFX_ADDR_CFG_OUT1TO3    8'h08
`define LFX_ADDR_CFG_OUT4TO6    8'h0A
`define LFX_ADDR_CFG_OUT7TO9    8'h0C

`define LFX_GCFG_ON_TIME_BIT    3
`define LFX_GCFG_TOUCH_FX_BIT   2
`define LFX_RESET_BYTE          8'h00

`define LFX_STEP_MS             20
`define LFX_CLK_HZ              40000000
`define LFX_STEP_CYCLES         (`LFX_STEP_MS * `LFX_CLK_HZ / 1000)
`define LFX_LEVELS              100
`define LFX_NUM_OUTPUTS         10

`endif

//--- lfx_pkg.sv
// Types shared by the LED touch effect block
package lfx_pkg;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_RAMP,
    PH_HOLD,
    PH_REPEAT,
    PH_ON_TIME
  } lfx_phase_t;

  // One touch-effect configuration byte
  typedef struct packed {
    logic [1:0] ramp_up_select;
    logic [2:0] high_brightness;
    logic [2:0] repeat_count_code;
  } lfx_fx_cfg_t;

  typedef struct packed {
    lfx_phase_t phase;
    logic [6:0] level;
    logic [7:0] sub;
    logic [2:0] reps;
    logic [7:0] hold;
  } lfx_chan_t;

  typedef struct packed {
    logic [7:0]            gcfg;
    logic [3:0][7:0]       period;
    lfx_fx_cfg_t [3:0]     fx_cfg;
    logic [23:0]           pre;
    logic [6:0]            cent;
    logic [6:0]            pwm;
    logic [7:0]            rdata;
    logic [9:0]            out_n;
    lfx_chan_t [9:0]       ch;
  } lfx_state_t;

endpackage

//--- lfx_touch_effect.sv
// LED touch effect timing registers, per-group ramp-up configuration and PWM output drive
`timescale 1ns/1ps
`default_nettype none
`include "lfx_defs.svh"

module lfx_touch_effect #(
  parameter int STEP_CYCLES = `LFX_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Register port, fed by the serial front end
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  output logic      [7:0] reg_rdata,
  // Button status from the sensing logic, same clock
  input  wire logic [9:0] button_touched,
  // LED drive, active low
  output logic      [9:0] active_low_output_n
);

  localparam int CENT_CYCLES = STEP_CYCLES / `LFX_LEVELS;

  if (CENT_CYCLES < 1 || CENT_CYCLES > 16777216) begin : g_bad_step
    $error("STEP_CYCLES must lie between 100 and 1677721600");
  end

  lfx_pkg::lfx_state_t s_q;
  lfx_pkg::lfx_state_t s_d;

  function automatic logic [6:0] intensity(input logic [2:0] code);
    case (code)
      3'h0:    intensity = 7'd100;
      3'h1:    intensity = 7'd90;
      3'h2:    intensity = 7'd80;
      3'h3:    intensity = 7'd65;
      3'h4:    intensity = 7'd50;
      3'h5:    intensity = 7'd40;
      3'h6:    intensity = 7'd20;
      default: intensity = 7'd0;
    endcase
  endfunction

  // repeat map, unlisted codes saturate at six
  function automatic logic [2:0] repeats(input logic [2:0] code);
    case (code)
      3'h0:    repeats = 3'h0;
      3'h1:    repeats = 3'h1;
      3'h2:    repeats = 3'h2;
      3'h3:    repeats = 3'h4;
      default: repeats = 3'h6;
    endcase
  endfunction

  function automatic logic [1:0] group_of(input int idx);
    if (idx == 0) begin
      group_of = 2'h0;
    end else if (idx <= 3) begin
      group_of = 2'h1;
    end else if (idx <= 6) begin
      group_of = 2'h2;
    end else begin
      group_of = 2'h3;
    end
  endfunction

  function automatic logic [7:0] reg_read(input lfx_pkg::lfx_state_t st, input logic [7:0] a);
    case (a)
      `LFX_ADDR_GLOBAL_CFG:                                        reg_read = st.gcfg;
      `LFX_ADDR_PERIOD_ONE, `LFX_ADDR_PERIOD_TWO,
      `LFX_ADDR_PERIOD_THREE, `LFX_ADDR_PERIOD_FOUR:               reg_read = st.period[a[1:0] - 2'h2];
      `LFX_ADDR_CFG_OUT0:                                          reg_read = st.fx_cfg[0];
      `LFX_ADDR_CFG_OUT1TO3:                                       reg_read = st.fx_cfg[1];
      `LFX_ADDR_CFG_OUT4TO6:                                       reg_read = st.fx_cfg[2];
      `LFX_ADDR_CFG_OUT7TO9:                                       reg_read = st.fx_cfg[3];
      default:                                                     reg_read = 8'h00;
    endcase
  endfunction

  logic                cent_tick;
  logic                step_tick;
  logic                fx_en;
  logic                on_time_en;
  lfx_pkg::lfx_fx_cfg_t cfg;
  logic [7:0]          per;
  logic [6:0]          tgt;
  logic [6:0]          ramp_lvl;
  logic [7:0]          ramp_sub;
  logic                at_tgt;

  always_comb begin
    s_d        = s_q;
    cfg        = '0;
    per        = 8'h00;
    tgt        = 7'd0;
    ramp_lvl   = 7'd0;
    ramp_sub   = 8'h00;
    at_tgt     = 1'b0;
    fx_en      = s_q.gcfg[`LFX_GCFG_TOUCH_FX_BIT];
    on_time_en = s_q.gcfg[`LFX_GCFG_ON_TIME_BIT];

    // 20 ms step split into 100 sub-ticks for duty stepping
    cent_tick = (s_q.pre == 24'(CENT_CYCLES - 1));
    step_tick = cent_tick && (s_q.cent == 7'(`LFX_LEVELS - 1));
    s_d.pre   = cent_tick ? 24'h000000 : s_q.pre + 24'h000001;
    if (cent_tick) begin
      s_d.cent = step_tick ? 7'd0 : s_q.cent + 7'd1;
    end
    s_d.pwm = (s_q.pwm == 7'(`LFX_LEVELS - 1)) ? 7'd0 : s_q.pwm + 7'd1;

    // register writes; unmapped offsets are ignored
    if (reg_wr) begin
      case (reg_addr)
        `LFX_ADDR_GLOBAL_CFG:                       s_d.gcfg = reg_wdata;
        `LFX_ADDR_PERIOD_ONE, `LFX_ADDR_PERIOD_TWO,
        `LFX_ADDR_PERIOD_THREE, `LFX_ADDR_PERIOD_FOUR: s_d.period[reg_addr[1:0] - 2'h2] = reg_wdata;
        `LFX_ADDR_CFG_OUT0:                         s_d.fx_cfg[0] = reg_wdata;
        `LFX_ADDR_CFG_OUT1TO3:                      s_d.fx_cfg[1] = reg_wdata;
        `LFX_ADDR_CFG_OUT4TO6:                      s_d.fx_cfg[2] = reg_wdata;
        `LFX_ADDR_CFG_OUT7TO9:                      s_d.fx_cfg[3] = reg_wdata;
        default: ;
      endcase
    end
    s_d.rdata = reg_read(s_q, reg_addr);

    for (int i = 0; i < `LFX_NUM_OUTPUTS; i++) begin
      // disabled effects: full brightness, no ramp, no repeats
      cfg = fx_en ? s_q.fx_cfg[group_of(i)] : '0;
      // ramp time from the selected period register
      per = fx_en ? s_q.period[cfg.ramp_up_select] : 8'h00;
      tgt = fx_en ? intensity(cfg.high_brightness) : 7'd100;

      // one duty step each time the sub counter reaches the period
      at_tgt   = (s_q.ch[i].level == tgt);
      ramp_lvl = s_q.ch[i].level;
      ramp_sub = s_q.ch[i].sub;
      if (per == 8'h00) begin
        ramp_lvl = tgt;
      end else if (cent_tick && !at_tgt) begin
        if (s_q.ch[i].sub >= per - 8'h01) begin
          ramp_sub = 8'h00;
          ramp_lvl = (s_q.ch[i].level < tgt) ? s_q.ch[i].level + 7'd1 : s_q.ch[i].level - 7'd1;
        end else begin
          ramp_sub = s_q.ch[i].sub + 8'h01;
        end
      end

      case (s_q.ch[i].phase)
        lfx_pkg::PH_IDLE: begin
          s_d.ch[i].level = 7'd0;
          if (button_touched[i]) begin
            s_d.ch[i].phase = lfx_pkg::PH_RAMP;
            s_d.ch[i].sub   = 8'h00;
          end
        end
        lfx_pkg::PH_RAMP, lfx_pkg::PH_HOLD: begin
          s_d.ch[i].level = ramp_lvl;
          s_d.ch[i].sub   = ramp_sub;
          s_d.ch[i].phase = at_tgt ? lfx_pkg::PH_HOLD : lfx_pkg::PH_RAMP;
          if (!button_touched[i]) begin
            s_d.ch[i].sub = 8'h00;
            if (repeats(cfg.repeat_count_code) != 3'h0 && fx_en) begin
              s_d.ch[i].phase = lfx_pkg::PH_REPEAT;
              s_d.ch[i].reps  = repeats(cfg.repeat_count_code);
              s_d.ch[i].level = 7'd0;
            end else if (on_time_en) begin
              s_d.ch[i].phase = lfx_pkg::PH_ON_TIME;
              s_d.ch[i].hold  = s_q.period[0];
            end else begin
              s_d.ch[i].phase = lfx_pkg::PH_IDLE;
              s_d.ch[i].level = 7'd0;
            end
          end
        end
        lfx_pkg::PH_REPEAT: begin
          s_d.ch[i].level = ramp_lvl;
          s_d.ch[i].sub   = ramp_sub;
          if (button_touched[i]) begin
            s_d.ch[i].phase = lfx_pkg::PH_RAMP;
          end else if (at_tgt) begin
            s_d.ch[i].reps  = s_q.ch[i].reps - 3'h1;
            s_d.ch[i].level = 7'd0;
            if (s_q.ch[i].reps == 3'h1) begin
              // on-time after the last repeat keeps the LED lit
              if (on_time_en) begin
                s_d.ch[i].phase = lfx_pkg::PH_ON_TIME;
                s_d.ch[i].hold  = s_q.period[0];
                s_d.ch[i].level = tgt;
              end else begin
                s_d.ch[i].phase = lfx_pkg::PH_IDLE;
              end
            end
          end
        end
        lfx_pkg::PH_ON_TIME: begin
          // hold lit for period one, counted in 20 ms steps
          if (button_touched[i]) begin
            s_d.ch[i].phase = lfx_pkg::PH_RAMP;
          end else if (step_tick) begin
            if (s_q.ch[i].hold == 8'h00) begin
              s_d.ch[i].phase = lfx_pkg::PH_IDLE;
              s_d.ch[i].level = 7'd0;
            end else begin
              s_d.ch[i].hold = s_q.ch[i].hold - 8'h01;
            end
          end
        end
        default: begin
          s_d.ch[i].phase = lfx_pkg::PH_IDLE;
        end
      endcase

      // duty cycle on the active-low pin
      s_d.out_n[i] = !(s_q.pwm < s_q.ch[i].level);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q       <= '0;
      s_q.out_n <= 10'h3FF;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata           = s_q.rdata;
  assign active_low_output_n = s_q.out_n;

endmodule
`default_nettype wire

//--- lfx_touch_effect_chk.sv
// Checker for the LED touch effect register port and LED pins
`timescale 1ns/1ps
`default_nettype none
module lfx_touch_effect_chk (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_rdata,
  // Buttons and LEDs
  input wire logic [9:0] button_touched,
  input wire logic [9:0] active_low_output_n
);
  logic [7:0] gcfg_q;
  // Shadow of the global enables, so pin checks know the mode
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      gcfg_q <= 8'h00;
    else if (reg_wr && reg_addr == 8'h01)
      gcfg_q <= reg_wdata;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_per_wr; reg_wr && reg_addr inside {[8'h02:8'h05]}; endsequence
  sequence s_cfg_wr; reg_wr && reg_addr inside {8'h06, 8'h08, 8'h0A, 8'h0C}; endsequence
  sequence s_keep; !reg_wr && $stable(reg_addr); endsequence
  a_release_idle: assert property (
    $rose(resetn) |-> active_low_output_n == 10'h3FF && reg_rdata == 8'h00) else $error("not idle after reset");
  a_unmapped_zero: assert property (
    reg_addr inside {8'h00, 8'h07, 8'h09, 8'h0B, 8'h0D, [8'h0E:8'hFF]} |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_period_back: assert property (
    s_per_wr ##1 s_keep |=> reg_rdata == $past(reg_wdata, 2)) else $error("period readback wrong");
  a_cfg_back: assert property (
    s_cfg_wr ##1 s_keep |=> reg_rdata == $past(reg_wdata, 2)) else $error("config readback wrong");
  a_gcfg_back: assert property (
    reg_wr && reg_addr == 8'h01 ##1 s_keep |=> reg_rdata == gcfg_q) else $error("global readback wrong");
  a_plain_on0: assert property (
    (!gcfg_q[2] && button_touched[0]) [*5] |-> !active_low_output_n[0]) else $error("out0 not full on");
  a_plain_on9: assert property (
    (!gcfg_q[2] && button_touched[9]) [*5] |-> !active_low_output_n[9]) else $error("out9 not full on");
  a_plain_dark: assert property (
    (gcfg_q[3:2] == 2'b00 && !button_touched[0]) [*5] |-> active_low_output_n[0]) else $error("out0 lit");
endmodule
bind lfx_touch_effect lfx_touch_effect_chk u_chk (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rdata, .button_touched, .active_low_output_n);
`default_nettype wire

//--- lfx_led_model.sv
// Behavioural LED that reports its lit cycles per 100-cycle window
`timescale 1ns/1ps
`default_nettype none
module lfx_led_model (
  // Clock
  input wire logic       core_clk,
  // Pins and the LED watched
  input wire logic [9:0] active_low_output_n,
  input wire logic [3:0] led_sel,
  // Lit cycles in last window
  output logic     [6:0] duty
);
  logic [6:0] win = 7'h00;
  logic [6:0] acc = 7'h00;
  logic [6:0] lit;
  assign lit = {6'h00, ~active_low_output_n[led_sel]};
  // Window need not align to the frame: a steady level still counts exactly
  always @(posedge core_clk) begin
    win <= (win == 7'h63) ? 7'h00 : win + 7'h01;
    acc <= (win == 7'h63) ? 7'h00 : acc + lit;
    if (win == 7'h63)
      duty <= acc + lit;
  end
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the LED touch effect block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       core_clk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic [7:0] reg_rdata;
  logic [9:0] button_touched = 10'h000;
  logic [9:0] active_low_output_n;
  logic [3:0] led_sel = 4'h0;
  logic [6:0] duty;
  int         errors = 0;
  int         check_count = 0;
  int         t;
  always #12.5 core_clk = ~core_clk;
  lfx_touch_effect #(.STEP_CYCLES(200)) uut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rdata, .button_touched, .active_low_output_n);
  lfx_led_model led (.core_clk, .active_low_output_n, .led_sel, .duty);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    tick(1);
    reg_addr = a;
    tick(1);
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  task automatic duty_is(input logic [6:0] exp);
    chk({9'h000, duty}, {9'h000, exp});
  endtask
  // Release all buttons, then count cycles until a whole window is dark
  task automatic dark;
    button_touched = 10'h000;
    for (t = 0; duty !== 7'h00 && t < 20000; t++)
      tick(1);
    // A LED that never goes dark counts as a mismatch
    if (t >= 20000) begin
      chk({9'h000, duty}, 16'h0000);
    end
  endtask
  task automatic in_range(input int lo, input int hi);
    chk({15'h0000, t >= lo && t <= hi}, 16'h0001);
  endtask
  task automatic t_regs;
    logic [7:0] a [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0A, 8'h0C};
    foreach (a[i]) rd(a[i], 8'h00);
    foreach (a[i]) begin
      wr(a[i], a[i] ^ 8'hA5);
      rd(a[i], a[i] ^ 8'hA5);
    end
    wr(8'h07, 8'h5A);
    rd(8'h07, 8'h00);
    foreach (a[i]) wr(a[i], 8'h00);
    $display("regs done");
  endtask
  task automatic t_bright;
    int         lx [4] = '{0, 2, 5, 9};
    logic [7:0] ca [4] = '{8'h06, 8'h08, 8'h0A, 8'h0C};
    logic [6:0] pc [8] = '{7'h64, 7'h5A, 7'h50, 7'h41, 7'h32, 7'h28, 7'h14, 7'h00};
    wr(8'h01, 8'h04);
    for (int k = 0; k < 8; k++) begin
      wr(ca[k % 4], {2'b00, 3'(k), 3'b000});
      led_sel = 4'(lx[k % 4]);
      button_touched[lx[k % 4]] = 1'b1;
      tick(250);
      duty_is(pc[k]);
      dark;
      wr(ca[k % 4], 8'h00);
    end
    $display("bright done");
  endtask
  task automatic t_ramp;
    led_sel = 4'h0;
    for (int s = 0; s < 4; s++) begin
      wr(8'(s + 2), 8'(2 * s + 2));
      wr(8'h06, {2'(s), 6'h00});
      button_touched[0] = 1'b1;
      tick((2 * s + 2) * 200 - 250);
      chk({15'h0000, duty < 7'h64}, 16'h0001);
      tick(500);
      duty_is(7'h64);
      dark;
    end
    $display("ramp done");
  endtask
  task automatic t_repeat;
    int n [8] = '{0, 1, 2, 4, 6, 6, 6, 6};
    wr(8'h02, 8'h01);
    for (int c = 0; c < 8; c++) begin
      wr(8'h06, {5'h00, 3'(c)});
      button_touched[0] = 1'b1;
      tick(450);
      duty_is(7'h64);
      dark;
      // Each repeat is one 200-cycle ramp; the window adds 100 to 200 cycles
      in_range(n[c] * 200 + 80, n[c] * 210 + 220);
    end
    $display("repeat done");
  endtask
  task automatic t_modes;
    wr(8'h01, 8'h00);
    wr(8'h06, 8'h3C);
    button_touched = 10'h201;
    tick(250);
    duty_is(7'h64);
    dark;
    in_range(0, 300);
    wr(8'h01, 8'h08);
    wr(8'h02, 8'h03);
    button_touched[0] = 1'b1;
    tick(250);
    duty_is(7'h64);
    dark;
    in_range(600, 1100);
    // On-time after the last repeat keeps the LED lit at target
    wr(8'h01, 8'h0C);
    wr(8'h02, 8'h01);
    wr(8'h06, 8'h01);
    button_touched[0] = 1'b1;
    tick(450);
    duty_is(7'h64);
    dark;
    in_range(480, 820);
    $display("modes done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    tick(6);
    resetn = 1'b1;
    t_regs;
    t_bright;
    t_ramp;
    t_repeat;
    t_modes;
    complete_run;
  end
  // Tests need about 25k cycles; allow 60k
  initial begin
    #1500000;
    errors++;
    complete_run;
  end
endmodule
`default_nettype wire
